/* include/cmsu_regs.svh */
// Register map, reset values, write masks, source codes, loop factors and timing counts
// Assumes inclusion by the clock mode switch unit and its package users
`ifndef CMSU_REGS_SVH
`define CMSU_REGS_SVH

// Register indices on the plain register port
`define CMSU_SRC_OFS      3'h0
`define CMSU_OSC_OFS      3'h1
`define CMSU_LOOP_OFS     3'h2
`define CMSU_STAT_OFS     3'h3

// Reset values: internal reference, loop output, output divide by two
`define CMSU_SRC_RST      8'h04
`define CMSU_OSC_RST      8'h40
`define CMSU_LOOP_RST     8'h00
`define CMSU_IREF_RST     2'h1

// Writable bits; the rest read as zero
`define CMSU_SRC_WMASK    8'hFC
`define CMSU_OSC_WMASK    8'hFE
`define CMSU_LOOP_WMASK   8'h4F

// Output source codes
`define CMSU_SRC_LOOP     2'h0
`define CMSU_SRC_INT      2'h1
`define CMSU_SRC_EXT      2'h2
`define CMSU_SRC_PLL      2'h3

// Loop factors and bus divide
`define CMSU_FLL_MULT     11'h400
`define CMSU_PLL_STEP     2
`define CMSU_BUS_SHIFT    1

// Settling counts in clk_in cycles
`define CMSU_SWITCH_CYC   16'h0004
`define CMSU_OSC_INIT_CYC 16'h0400
`define CMSU_LOCK_CYC     16'h0200

`endif

/* include/cmsu_pkg.sv */
// Types of the clock mode switch unit
// Assumes cmsu_regs.svh holds the numbers
package cmsu_pkg;

	typedef struct packed {
		logic [1:0] out_div;
		logic       range_hi;
		logic       gain_hi;
		logic       low_power;
		logic       crystal;
		logic       ext_ref_en;
		logic       unused0;
	} cmsu_osc_ctl_t;

	typedef struct packed {
		logic [1:0] out_sel;
		logic [2:0] ref_div;
		logic       int_ref;
		logic [1:0] unused;
	} cmsu_src_ctl_t;

	typedef struct packed {
		logic       unused7;
		logic       loop_sel;
		logic [1:0] unused;
		logic [3:0] loop_mult;
	} cmsu_loop_ctl_t;

	typedef struct packed {
		logic       unused7;
		logic       lock;
		logic       pll_st;
		logic       iref_st;
		logic [1:0] out_st;
		logic       osc_ready;
		logic       unused0;
	} cmsu_status_t;

	typedef struct packed {
		logic range_hi;
		logic gain_hi;
		logic crystal;
		logic ext_ref_en;
	} cmsu_osc_pins_t;

	typedef enum logic [3:0] {
		CMSU_FEI, CMSU_FEE, CMSU_FBI, CMSU_FBE, CMSU_PEE,
		CMSU_PBE, CMSU_LOW_POWER_BYPASS_INTERNAL, CMSU_LOW_POWER_BYPASS_EXTERNAL
	} cmsu_mode_t;

endpackage

/* hdl/cmsu_clock_mode_switch_unit.sv */
// Clock mode switch unit: control registers, status tracking, loop enables
// Assumes a single clk_in domain and a plain one-cycle register port
//
// Operation
// - Output divider at control bits 7:6; zero divides by one.
// - Bit 5 picks high range, bit 4 picks high gain oscillator.
// - Bit 2 selects crystal; bit 1 keeps external reference active.
// - Oscillator ready status reads one after crystal initialisation finishes.
// - Output select 00 loop, 01 internal, 10 external reference.
// - Reference divider bits 5:3 divide by two to the power of field.
// - Reference select bit 2: clear external, set internal.
// - Reference status zero for external, one once internal is active.
// - Output status shows FLL, internal, external or PLL actually driving.
// - Loop select bit 6 picks PLL; multiplier ignored under FLL.
// - Multiplier bits 3:0; value four makes PLL multiply by sixteen.
// - Loop status bit set when PLL is loop source.
// - Lock status sets once the selected loop has locked.
// - Low power bit in a bypass mode enters low power bypass; clearing resumes loop.
// - Low power bypass disables both loops; settings only prepared.
// - FBE, and FBI with the FLL selected, keep the FLL running and able to lock.
// - Bus clock is generated clock halved; PLL ratio is ext/R*M/B.
// - Reset enters FLL engaged internal mode with divide by two.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "cmsu_regs.svh"

module cmsu_clock_mode_switch_unit #(
	parameter logic [15:0] SW_CYC   = `CMSU_SWITCH_CYC,
	parameter logic [15:0] OSC_CYC  = `CMSU_OSC_INIT_CYC,
	parameter logic [15:0] LOCK_CYC = `CMSU_LOCK_CYC
) (
	input  wire logic                    clk_in,      // 200 MHz clock
	input  wire logic                    rst_n_in,    // Synchronous reset
	input  wire logic [2:0]              addr_in,     // Register index
	input  wire logic [7:0]              wdata_in,    // Write data
	input  wire logic                    wr_in,       // Write strobe
	input  wire logic                    rd_in,       // Read strobe
	output logic      [7:0]              rdata_out,   // Read data, next cycle
	output cmsu_pkg::cmsu_mode_t         mode_out,    // Current clock mode
	output logic      [1:0]              gen_src_out, // Source on generated clock
	output logic                         fll_en_out,  // FLL running
	output logic                         pll_en_out,  // PLL running
	output logic                         osc_en_out,  // Oscillator running
	output cmsu_pkg::cmsu_osc_pins_t     osc_cfg_out, // Oscillator setup
	output logic      [7:0]              ref_div_out, // Reference divide ratio
	output logic      [10:0]             mult_out,    // Loop multiply ratio
	output logic      [7:0]              out_div_out, // Output divide ratio
	output logic      [8:0]              bus_div_out  // Bus divide ratio
);

	cmsu_pkg::cmsu_osc_ctl_t  osc_reg,  osc_next;
	cmsu_pkg::cmsu_src_ctl_t  src_reg,  src_next;
	cmsu_pkg::cmsu_loop_ctl_t loop_reg, loop_next;
	cmsu_pkg::cmsu_status_t   stat;
	logic [7:0]  rdata_reg, rdata_next;

	// Register port
	always_comb begin
		osc_next   = osc_reg;
		src_next   = src_reg;
		loop_next  = loop_reg;
		rdata_next = 8'h00;
		if (wr_in) begin
			case (addr_in)
				`CMSU_SRC_OFS:  src_next  = wdata_in & `CMSU_SRC_WMASK;
				`CMSU_OSC_OFS:  osc_next  = wdata_in & `CMSU_OSC_WMASK;
				`CMSU_LOOP_OFS: loop_next = wdata_in & `CMSU_LOOP_WMASK;
				default: ;
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				`CMSU_SRC_OFS:  rdata_next = src_reg;
				`CMSU_OSC_OFS:  rdata_next = osc_reg;
				`CMSU_LOOP_OFS: rdata_next = loop_reg;
				`CMSU_STAT_OFS: rdata_next = stat;
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			osc_reg   <= `CMSU_OSC_RST;
			src_reg   <= `CMSU_SRC_RST;
			loop_reg  <= `CMSU_LOOP_RST;
			rdata_reg <= 8'h00;
		end else begin
			osc_reg   <= osc_next;
			src_reg   <= src_next;
			loop_reg  <= loop_next;
			rdata_reg <= rdata_next;
		end
	end

	// Oscillator start-up
	logic        osc_on;
	logic        osc_ready_reg, osc_ready_next;
	logic [15:0] osc_cnt_reg, osc_cnt_next;

	assign osc_on = osc_reg.ext_ref_en | ~src_reg.int_ref
		| (src_reg.out_sel == `CMSU_SRC_EXT);

	always_comb begin
		osc_ready_next = osc_ready_reg;
		osc_cnt_next   = osc_cnt_reg;
		if (!osc_on || !osc_reg.crystal) begin
			osc_ready_next = 1'b0;
			osc_cnt_next   = 16'h0000;
		end else if (!osc_ready_reg) begin
			if (osc_cnt_reg == OSC_CYC - 16'h0001) begin
				osc_ready_next = 1'b1;
			end else begin
				osc_cnt_next = osc_cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			osc_ready_reg <= 1'b0;
			osc_cnt_reg   <= 16'h0000;
		end else begin
			osc_ready_reg <= osc_ready_next;
			osc_cnt_reg   <= osc_cnt_next;
		end
	end

	// Switch trackers: 0 reference, 1 loop, 2 output source
	logic [1:0]  trk_tgt [3];
	logic        trk_ok [3];
	logic [1:0]  trk_cur_reg [3];
	logic [1:0]  trk_cur_next [3];
	logic [15:0] trk_cnt_reg [3];
	logic [15:0] trk_cnt_next [3];

	always_comb begin
		trk_tgt[0] = {1'b0, src_reg.int_ref};
		trk_ok[0]  = src_reg.int_ref | osc_ready_reg | ~osc_reg.crystal;
		trk_tgt[1] = {1'b0, loop_reg.loop_sel};
		trk_ok[1]  = 1'b1;
		case (src_reg.out_sel)
			`CMSU_SRC_LOOP: trk_tgt[2] = trk_cur_reg[1][0] ? `CMSU_SRC_PLL
				: `CMSU_SRC_LOOP;
			`CMSU_SRC_INT:  trk_tgt[2] = `CMSU_SRC_INT;
			`CMSU_SRC_EXT:  trk_tgt[2] = `CMSU_SRC_EXT;
			default:        trk_tgt[2] = trk_cur_reg[2];
		endcase
		trk_ok[2] = 1'b1;
	end

	// Settling delay keeps status behind the real source
	generate
		for (genvar g = 0; g < 3; g++) begin : g_trk
			always_comb begin
				trk_cur_next[g] = trk_cur_reg[g];
				trk_cnt_next[g] = 16'h0000;
				if (trk_cur_reg[g] != trk_tgt[g] && trk_ok[g]) begin
					if (trk_cnt_reg[g] == SW_CYC - 16'h0001) begin
						trk_cur_next[g] = trk_tgt[g];
					end else begin
						trk_cnt_next[g] = trk_cnt_reg[g] + 16'h0001;
					end
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					trk_cur_reg[g] <= (g == 0) ? `CMSU_IREF_RST : 2'h0;
					trk_cnt_reg[g] <= 16'h0000;
				end else begin
					trk_cur_reg[g] <= trk_cur_next[g];
					trk_cnt_reg[g] <= trk_cnt_next[g];
				end
			end
		end
	endgenerate

	logic       iref_st;
	logic       pll_st;
	logic [1:0] out_st;
	logic       lp_act;
	logic       loop_on;

	assign iref_st = trk_cur_reg[0][0];
	assign pll_st  = trk_cur_reg[1][0];
	assign out_st  = trk_cur_reg[2];
	assign lp_act  = osc_reg.low_power
		& (out_st == `CMSU_SRC_INT || out_st == `CMSU_SRC_EXT);
	assign loop_on = ~lp_act;

	// Lock: any change of reference, divider or loop select restarts acquisition; a multiplier change does so only under the PLL
	logic [8:0]  key;
	logic [8:0]  key_reg;
	logic        lock_reg, lock_next;
	logic [15:0] lock_cnt_reg, lock_cnt_next;

	assign key = {iref_st, pll_st, src_reg.ref_div,
		loop_reg.loop_mult & {4{pll_st}}};

	always_comb begin
		lock_next     = lock_reg;
		lock_cnt_next = lock_cnt_reg;
		if (!loop_on || key != key_reg) begin
			lock_next     = 1'b0;
			lock_cnt_next = 16'h0000;
		end else if (!lock_reg) begin
			if (lock_cnt_reg == LOCK_CYC - 16'h0001) begin
				lock_next = 1'b1;
			end else begin
				lock_cnt_next = lock_cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			key_reg      <= 9'h000;
			lock_reg     <= 1'b0;
			lock_cnt_reg <= 16'h0000;
		end else begin
			key_reg      <= key;
			lock_reg     <= lock_next;
			lock_cnt_reg <= lock_cnt_next;
		end
	end

	always_comb begin
		stat           = '0;
		stat.lock      = lock_reg;
		stat.pll_st    = pll_st;
		stat.iref_st   = iref_st;
		stat.out_st    = out_st;
		stat.osc_ready = osc_ready_reg;
	end

	// Registered outputs
	cmsu_pkg::cmsu_mode_t     mode_reg, mode_next;
	cmsu_pkg::cmsu_osc_pins_t pins_reg, pins_next;
	logic [1:0]  src_o_reg, src_o_next;
	logic        fll_reg, fll_next;
	logic        pll_reg, pll_next;
	logic        osc_o_reg, osc_o_next;
	logic [7:0]  reference_divider_reg, reference_divider_next;
	logic [10:0] mult_reg, mult_next;
	logic [7:0]  output_divider_reg, output_divider_next;
	logic [8:0]  bus_reg, bus_next;

	always_comb begin
		case (out_st)
			`CMSU_SRC_LOOP: mode_next = iref_st ? cmsu_pkg::CMSU_FEI
				: cmsu_pkg::CMSU_FEE;
			`CMSU_SRC_PLL:  mode_next = cmsu_pkg::CMSU_PEE;
			`CMSU_SRC_INT:  mode_next = lp_act ? cmsu_pkg::CMSU_LOW_POWER_BYPASS_INTERNAL
				: cmsu_pkg::CMSU_FBI;
			default: begin
				if (lp_act) begin
					mode_next = cmsu_pkg::CMSU_LOW_POWER_BYPASS_EXTERNAL;
				end else begin
					mode_next = pll_st ? cmsu_pkg::CMSU_PBE : cmsu_pkg::CMSU_FBE;
				end
			end
		endcase
		pins_next.range_hi   = osc_reg.range_hi;
		pins_next.gain_hi    = osc_reg.gain_hi;
		pins_next.crystal    = osc_reg.crystal;
		pins_next.ext_ref_en = osc_reg.ext_ref_en;
		src_o_next = out_st;
		fll_next   = loop_on & ~pll_st;
		pll_next   = loop_on & pll_st;
		osc_o_next = osc_on;
		reference_divider_next  = 8'h01 << src_reg.ref_div;
		case (out_st)
			`CMSU_SRC_PLL:  mult_next = 11'({7'h00, loop_reg.loop_mult}
				<< `CMSU_PLL_STEP);
			`CMSU_SRC_LOOP: mult_next = `CMSU_FLL_MULT;
			default:        mult_next = 11'h001;
		endcase
		output_divider_next  = 8'h01 << osc_reg.out_div;
		bus_next   = 9'({1'b0, output_divider_next} << `CMSU_BUS_SHIFT);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_reg  <= cmsu_pkg::CMSU_FEI;
			pins_reg  <= '0;
			src_o_reg <= 2'h0;
			fll_reg   <= 1'b1;
			pll_reg   <= 1'b0;
			osc_o_reg <= 1'b0;
			reference_divider_reg  <= 8'h01;
			mult_reg  <= `CMSU_FLL_MULT;
			output_divider_reg  <= 8'h02;
			bus_reg   <= 9'h004;
		end else begin
			mode_reg  <= mode_next;
			pins_reg  <= pins_next;
			src_o_reg <= src_o_next;
			fll_reg   <= fll_next;
			pll_reg   <= pll_next;
			osc_o_reg <= osc_o_next;
			reference_divider_reg  <= reference_divider_next;
			mult_reg  <= mult_next;
			output_divider_reg  <= output_divider_next;
			bus_reg   <= bus_next;
		end
	end

	assign rdata_out   = rdata_reg;
	assign mode_out    = mode_reg;
	assign osc_cfg_out = pins_reg;
	assign gen_src_out = src_o_reg;
	assign fll_en_out  = fll_reg;
	assign pll_en_out  = pll_reg;
	assign osc_en_out  = osc_o_reg;
	assign ref_div_out = reference_divider_reg;
	assign mult_out    = mult_reg;
	assign out_div_out = output_divider_reg;
	assign bus_div_out = bus_reg;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_div_one_map: assert property (
		osc_reg.out_div == 2'h0 |=> out_div_out == 8'h01)
		else $error("output divider zero not divide by one");
	a_gain_range: assert property (
		osc_reg.range_hi && osc_reg.gain_hi |=> osc_cfg_out.range_hi && osc_cfg_out.gain_hi)
		else $error("range or gain not passed to oscillator");
	a_osc_ready_src: assert property (
		$rose(osc_ready_reg) |-> $past(osc_cnt_reg) == OSC_CYC - 16'h0001
		&& $past(osc_reg.crystal))
		else $error("oscillator ready before initialisation");
	a_reference_divider_map: assert property (
		src_reg.ref_div == 3'h7 |=> ref_div_out == 8'h80)
		else $error("reference divider 7 not 128");
	a_out_status_lag: assert property (
		$changed(out_st) |-> $past(trk_cnt_reg[2]) == SW_CYC - 16'h0001)
		else $error("output status changed before settling");
	a_pll_mult: assert property (
		out_st == `CMSU_SRC_PLL && loop_reg.loop_mult == 4'h4 |=> mult_out == 11'h010)
		else $error("multiplier 4 not times 16");
	a_pll_status: assert property (
		pll_en_out |-> $past(pll_st) && !fll_en_out)
		else $error("PLL running without loop status");
	a_lock_drop: assert property (
		lp_act |=> !lock_reg ##1 !lock_reg)
		else $error("lock held with loops off");
	a_lp_loops_off: assert property (
		mode_out == cmsu_pkg::CMSU_LOW_POWER_BYPASS_EXTERNAL |-> !fll_en_out && !pll_en_out)
		else $error("loop running in low power bypass");
	a_bypass_fll_on: assert property (
		mode_out == cmsu_pkg::CMSU_FBE || mode_out == cmsu_pkg::CMSU_FBI
		|-> fll_en_out)
		else $error("FLL stopped in bypass mode");
	a_bus_half: assert property (
		bus_div_out == {out_div_out, 1'b0})
		else $error("bus clock not half generated clock");
	a_reset_mode: assert property (
		@(posedge clk_in) disable iff (1'b0)
		!rst_n_in |=> mode_out == cmsu_pkg::CMSU_FEI && out_div_out == 8'h02)
		else $error("reset mode not engaged internal divide two");

	c_reach_pee:  cover property (mode_out == cmsu_pkg::CMSU_PEE && lock_reg);
	c_reach_low_power_bypass_internal: cover property (mode_out == cmsu_pkg::CMSU_LOW_POWER_BYPASS_INTERNAL);
	c_reach_low_power_bypass_external: cover property (mode_out == cmsu_pkg::CMSU_LOW_POWER_BYPASS_EXTERNAL);
	c_reach_fee:  cover property (mode_out == cmsu_pkg::CMSU_FEE && lock_reg);

endmodule

/* test/tb_clock_mode_switch_unit.sv */
// Testbench for the clock mode switch unit: software mode sequences
// Assumes include/ on the include path and the package compiled first
`timescale 1ns/100ps
`include "cmsu_regs.svh"

module tb_clock_mode_switch_unit;
	localparam logic [2:0] SRC  = `CMSU_SRC_OFS;
	localparam logic [2:0] OSC  = `CMSU_OSC_OFS;
	localparam logic [2:0] LOOP = `CMSU_LOOP_OFS;
	localparam logic [2:0] STAT = `CMSU_STAT_OFS;

	logic                     clk_in   = 1'b0;
	logic                     rst_n_in = 1'b0;
	logic [2:0]               addr_in  = 3'h0;
	logic [7:0]               wdata_in = 8'h00;
	logic                     wr_in    = 1'b0;
	logic                     rd_in    = 1'b0;
	logic [7:0]               rdata_out;
	cmsu_pkg::cmsu_mode_t     mode_out;
	logic [1:0]               gen_src_out;
	logic                     fll_en_out;
	logic                     pll_en_out;
	logic                     osc_en_out;
	cmsu_pkg::cmsu_osc_pins_t osc_cfg_out;
	logic [7:0]               ref_div_out;
	logic [10:0]              mult_out;
	logic [7:0]               out_div_out;
	logic [8:0]               bus_div_out;
	logic [7:0]               rd_val;
	int                       n_fail      = 0;
	int                       checks_done = 0;
	int                       cycles      = 0;

	always #2.5 clk_in = ~clk_in;

	// Short settling counts keep the run brief
	cmsu_clock_mode_switch_unit #(
		.SW_CYC  (16'h0004),
		.OSC_CYC (16'h0008),
		.LOCK_CYC(16'h0008)
	) cmsu_clock_mode_switch_unit_i (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.addr_in    (addr_in),
		.wdata_in   (wdata_in),
		.wr_in      (wr_in),
		.rd_in      (rd_in),
		.rdata_out  (rdata_out),
		.mode_out   (mode_out),
		.gen_src_out(gen_src_out),
		.fll_en_out (fll_en_out),
		.pll_en_out (pll_en_out),
		.osc_en_out (osc_en_out),
		.osc_cfg_out(osc_cfg_out),
		.ref_div_out(ref_div_out),
		.mult_out   (mult_out),
		.out_div_out(out_div_out),
		.bus_div_out(bus_div_out)
	);

	task automatic end_of_test;
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		rd_val = rdata_out;
	endtask

	task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] exp);
		rd(a);
		chk(what, {8'h00, rd_val}, {8'h00, exp});
	endtask

	task automatic settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	// Bounded status polling, as software would do it
	task automatic poll(input logic [7:0] mask, input logic [7:0] val);
		int i;
		for (i = 0; i < 100; i++) begin
			rd(STAT);
			if ((rd_val & mask) === val) break;
		end
		chk("status poll", {8'h00, rd_val & mask}, {8'h00, val});
		settle;
	endtask

	task automatic mode_is(input cmsu_pkg::cmsu_mode_t m);
		chk("mode", {12'h000, mode_out}, {12'h000, m});
	endtask

	// Whole sequence needs a few thousand cycles at most
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test;
		end
	end

	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		settle;
		mode_is(cmsu_pkg::CMSU_FEI);
		chk("out div", {8'h00, out_div_out}, 16'h0002);
		chk("bus div", {7'h00, bus_div_out}, 16'h0004);
		chk("fll en", {15'h0000, fll_en_out}, 16'h0001);
		chk("pll en", {15'h0000, pll_en_out}, 16'h0000);
		chk("gen src", {14'h0000, gen_src_out}, 16'h0000);
		// Read before the FLL can have locked
		rdchk("status", STAT, 8'h10);
		rdchk("source select", SRC, 8'h04);
		rdchk("osc control", OSC, 8'h40);
		rdchk("loop control", LOOP, 8'h00);
		// Status is read-only, unmapped space reads zero
		wr(STAT, 8'hFF);
		wr(3'h5, 8'hFF);
		rdchk("status", STAT, 8'h50);
		rdchk("unmapped", 3'h5, 8'h00);
		// Reserved bits dropped, multiplier kept; loop select left on the FLL
		wr(LOOP, 8'hBF);
		rdchk("loop control", LOOP, 8'h0F);
		wr(LOOP, 8'h0F);
		settle;
		chk("mult", {5'h00, mult_out}, 16'h0400);
		// Into external bypass
		wr(OSC, 8'h36);
		settle;
		chk("osc cfg", {12'h000, osc_cfg_out}, 16'h000F);
		chk("out div", {8'h00, out_div_out}, 16'h0001);
		chk("bus div", {7'h00, bus_div_out}, 16'h0002);
		chk("osc en", {15'h0000, osc_en_out}, 16'h0001);
		poll(8'h02, 8'h02);
		wr(SRC, 8'hB8);
		rd(STAT);
		chk("early status", {8'h00, rd_val & 8'h1C}, 16'h0010);
		poll(8'h1C, 8'h08);
		mode_is(cmsu_pkg::CMSU_FBE);
		chk("gen src", {14'h0000, gen_src_out}, 16'h0002);
		chk("ref div", {8'h00, ref_div_out}, 16'h0080);
		chk("fll en", {15'h0000, fll_en_out}, 16'h0001);
		poll(8'h40, 8'h40);
		// Low-power external bypass, then prepare the PLL
		wr(OSC, 8'h3E);
		settle;
		mode_is(cmsu_pkg::CMSU_LOW_POWER_BYPASS_EXTERNAL);
		chk("fll en", {15'h0000, fll_en_out}, 16'h0000);
		wr(SRC, 8'h90);
		wr(LOOP, 8'h44);
		poll(8'h20, 8'h20);
		chk("ref div", {8'h00, ref_div_out}, 16'h0004);
		chk("pll en", {15'h0000, pll_en_out}, 16'h0000);
		mode_is(cmsu_pkg::CMSU_LOW_POWER_BYPASS_EXTERNAL);
		wr(OSC, 8'h36);
		settle;
		mode_is(cmsu_pkg::CMSU_PBE);
		chk("pll en", {15'h0000, pll_en_out}, 16'h0001);
		poll(8'h40, 8'h40);
		wr(SRC, 8'h10);
		poll(8'h0C, 8'h0C);
		mode_is(cmsu_pkg::CMSU_PEE);
		chk("gen src", {14'h0000, gen_src_out}, 16'h0003);
		chk("mult", {5'h00, mult_out}, 16'h0010);
		// Back down to internal low power
		wr(SRC, 8'h90);
		poll(8'h0C, 8'h08);
		mode_is(cmsu_pkg::CMSU_PBE);
		wr(OSC, 8'h3E);
		wr(SRC, 8'hB8);
		wr(LOOP, 8'h04);
		wr(OSC, 8'h36);
		poll(8'h20, 8'h00);
		mode_is(cmsu_pkg::CMSU_FBE);
		poll(8'h40, 8'h40);
		wr(SRC, 8'h44);
		poll(8'h1C, 8'h14);
		mode_is(cmsu_pkg::CMSU_FBI);
		chk("ref div", {8'h00, ref_div_out}, 16'h0001);
		wr(OSC, 8'h08);
		settle;
		mode_is(cmsu_pkg::CMSU_LOW_POWER_BYPASS_INTERNAL);
		// Out to FLL engaged external
		wr(OSC, 8'h00);
		settle;
		mode_is(cmsu_pkg::CMSU_FBI);
		chk("fll en", {15'h0000, fll_en_out}, 16'h0001);
		wr(OSC, 8'h36);
		poll(8'h02, 8'h02);
		wr(SRC, 8'h38);
		poll(8'h1C, 8'h00);
		mode_is(cmsu_pkg::CMSU_FEE);
		chk("mult", {5'h00, mult_out}, 16'h0400);
		chk("ref div", {8'h00, ref_div_out}, 16'h0080);
		end_of_test;
	end
endmodule
